// ### rtl/piru_pkg.sv
package piru_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [29:0] PIRU_IDX_PEND0 = 30'h0000_0fc0;
  localparam logic [29:0] PIRU_IDX_EN0H  = 30'h0000_0fc1;
  localparam logic [29:0] PIRU_IDX_EN0L  = 30'h0000_0fc2;
  localparam logic [29:0] PIRU_IDX_PEND1 = 30'h0000_0fc3;
  localparam logic [29:0] PIRU_IDX_EN1H  = 30'h0000_0fc4;
  localparam logic [29:0] PIRU_IDX_EN1L  = 30'h0000_0fc5;
  localparam logic [29:0] PIRU_IDX_PEND2 = 30'h0000_0fc6;
  localparam logic [29:0] PIRU_IDX_EN2H  = 30'h0000_0fc7;
  localparam logic [29:0] PIRU_IDX_EN2L  = 30'h0000_0fc8;
  localparam logic [29:0] PIRU_IDX_CTRL  = 30'h0000_0fcf;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam logic [23:0] PIRU_VALID_FLAT = 24'h0f_ff79;
  localparam logic [23:0] PIRU_PEND_RST   = 24'h00_0000;
  localparam logic [23:0] PIRU_EN_RST     = 24'h00_0000;
  localparam logic        PIRU_GATE_RST   = 1'b0;
  localparam int unsigned PIRU_CTRL_GATE_BIT = 7;

  // ----------------------------------------------------------------
  // Source ranking: 0 watchdog, 1..3 traps, then ordinary sources
  // ----------------------------------------------------------------
  localparam int unsigned PIRU_NUM_ORD  = 17;
  localparam int unsigned PIRU_NUM_TRAP = 3;
  localparam int unsigned PIRU_NUM_SRC  = 21;
  localparam int unsigned PIRU_VEC_W    = 5;
  localparam int unsigned PIRU_SRC_ORD0 = 4;
  localparam logic [1:0]  PIRU_LVL_3    = 2'b11;
  localparam logic [1:0]  PIRU_LVL_2    = 2'b10;
  localparam logic [1:0]  PIRU_LVL_1    = 2'b01;

  // Flat pending bit of each ordinary source, highest rank first
  localparam int unsigned PIRU_ORD_MAP [PIRU_NUM_ORD] = '{6, 5, 4, 3, 0,
                                                          15, 14, 13, 12, 11, 10, 9, 8,
                                                          19, 18, 17, 16};

  typedef enum logic [1:0] {
    BUS_IDLE   = 2'b00,
    BUS_WRITE  = 2'b01,
    BUS_RDWAIT = 2'b10,
    BUS_RDDATA = 2'b11
  } piru_bus_t;

endpackage

// ### rtl/piru_prio_enc.sv
`timescale 1ns/10ps
`default_nettype none
module piru_prio_enc
  import piru_pkg::*;
#(
  parameter int unsigned NSRC  = 21,
  parameter int unsigned IDX_W = 5
) (
  input  wire logic [NSRC-1:0]   req,
  input  wire logic [2*NSRC-1:0] lvl,
  output logic                   valid,
  output logic [IDX_W-1:0]       idx,
  output logic [1:0]             win_lvl
);

  logic [NSRC-1:0] hit3;
  logic [NSRC-1:0] hit2;
  logic [NSRC-1:0] hit1;
  logic [NSRC-1:0] sel;

  // ----------------------------------------------------------------
  // Per-source level decode, code 00 never hits
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NSRC; g++) begin : g_lvl
    assign hit3[g] = req[g] && (lvl[2*g +: 2] == PIRU_LVL_3);
    assign hit2[g] = req[g] && (lvl[2*g +: 2] == PIRU_LVL_2);
    assign hit1[g] = req[g] && (lvl[2*g +: 2] == PIRU_LVL_1);
  end

  // Higher level always beats lower
  assign sel     = (|hit3) ? hit3 : (|hit2) ? hit2 : hit1;
  assign win_lvl = (|hit3) ? PIRU_LVL_3 : (|hit2) ? PIRU_LVL_2 : (|hit1) ? PIRU_LVL_1 : 2'b00;
  assign valid   = |sel;

  // Lowest index wins within a level
  always_comb begin
    idx = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (sel[i]) begin
        idx = IDX_W'(i);
      end
    end
  end

endmodule
`default_nettype wire

// ### rtl/piru_top.sv
// Operation
// - Level 3 beats 2, 2 beats 1
// - Same level: fixed vector table order
// - Watchdog and traps always top level
// - Acknowledge clears matching pending bit
// - Software writing 0 clears pending bit
// - Software writing 1 sets pending bit
// - Watchdog request is a held level
// - Request sets pending bit until cleared
// - Master gate forwards ordinary and watchdog winner, else polling
// - Peripheral register bit layout, reserved zero
// - Port A pins onto bits 7..0
// - Port C pins onto bits 3..0
// - Watchdog and oscillator traps bypass enables
// - Two enable bits encode level
// - Master gate set and clear events
`timescale 1ns/10ps
`default_nettype none
module piru_top
  import piru_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic             HREADYOUT,
  output logic             HRESP,
  output logic [31:0]      HRDATA,
  input  wire logic [7:0]  PERIPH_REQ,
  input  wire logic [7:0]  PORT_A_REQ,
  input  wire logic [3:0]  PORT_C_REQ,
  input  wire logic        WDT_REQ,
  input  wire logic        WDT_IRQ_EN,
  input  wire logic        PRIM_OSC_FAIL,
  input  wire logic        WDT_OSC_FAIL,
  input  wire logic        ILLEGAL_TRAP,
  input  wire logic        EI_EXEC,
  input  wire logic        DI_EXEC,
  input  wire logic        IRET_EXEC,
  input  wire logic        TRAP_EXEC,
  input  wire logic        INT_ACK,
  output logic             INT_REQ,
  output logic [4:0]       INT_VECTOR,
  output logic             IRQ_ENABLE
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  piru_bus_t                   bus_ff;
  piru_bus_t                   nxt_bus;
  logic [29:0]                 addr_ff;
  logic [31:0]                 rdata_ff;
  logic [23:0]                 pend_ff;
  logic [23:0]                 nxt_pend;
  logic [23:0]                 enh_ff;
  logic [23:0]                 enl_ff;
  logic [2:0]                  trap_ff;
  logic [2:0]                  nxt_trap;
  logic                        gate_ff;
  logic                        nxt_gate;
  logic                        req_ff;
  logic [PIRU_VEC_W-1:0]       vec_ff;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire addr_take = HSEL && HTRANS[1] && HREADY;
  wire wr_en     = (bus_ff == BUS_WRITE);
  wire wr_p0     = wr_en && (addr_ff == PIRU_IDX_PEND0);
  wire wr_p1     = wr_en && (addr_ff == PIRU_IDX_PEND1);
  wire wr_p2     = wr_en && (addr_ff == PIRU_IDX_PEND2);
  wire wr_h0     = wr_en && (addr_ff == PIRU_IDX_EN0H);
  wire wr_h1     = wr_en && (addr_ff == PIRU_IDX_EN1H);
  wire wr_h2     = wr_en && (addr_ff == PIRU_IDX_EN2H);
  wire wr_l0     = wr_en && (addr_ff == PIRU_IDX_EN0L);
  wire wr_l1     = wr_en && (addr_ff == PIRU_IDX_EN1L);
  wire wr_l2     = wr_en && (addr_ff == PIRU_IDX_EN2L);
  wire wr_ctrl   = wr_en && (addr_ff == PIRU_IDX_CTRL);

  wire [23:0] wdata_flat = {3{HWDATA[7:0]}};
  wire [23:0] wr_pend    = {{8{wr_p2}}, {8{wr_p1}}, {8{wr_p0}}};
  wire [23:0] wr_enh     = {{8{wr_h2}}, {8{wr_h1}}, {8{wr_h0}}};
  wire [23:0] wr_enl     = {{8{wr_l2}}, {8{wr_l1}}, {8{wr_l0}}};

  wire [7:0] rd_mux =
    (addr_ff == PIRU_IDX_PEND0) ? pend_ff[7:0]   :
    (addr_ff == PIRU_IDX_PEND1) ? pend_ff[15:8]  :
    (addr_ff == PIRU_IDX_PEND2) ? pend_ff[23:16] :
    (addr_ff == PIRU_IDX_EN0H)  ? enh_ff[7:0]    :
    (addr_ff == PIRU_IDX_EN1H)  ? enh_ff[15:8]   :
    (addr_ff == PIRU_IDX_EN2H)  ? enh_ff[23:16]  :
    (addr_ff == PIRU_IDX_EN0L)  ? enl_ff[7:0]    :
    (addr_ff == PIRU_IDX_EN1L)  ? enl_ff[15:8]   :
    (addr_ff == PIRU_IDX_EN2L)  ? enl_ff[23:16]  :
    (addr_ff == PIRU_IDX_CTRL)  ? {gate_ff, 7'h00} : 8'h00;

  always_comb begin
    case (bus_ff)
      BUS_RDWAIT: nxt_bus = BUS_RDDATA;
      BUS_IDLE, BUS_WRITE, BUS_RDDATA: begin
        if (addr_take) begin
          nxt_bus = HWRITE ? BUS_WRITE : BUS_RDWAIT;
        end else begin
          nxt_bus = BUS_IDLE;
        end
      end
      default: nxt_bus = BUS_IDLE;
    endcase
  end

  // One wait state on reads so the data come from a flip-flop
  assign HREADYOUT = (bus_ff != BUS_RDWAIT);
  assign HRESP     = 1'b0;
  assign HRDATA    = rdata_ff;

  // ----------------------------------------------------------------
  // Watchdog request from its slower clock domain
  // ----------------------------------------------------------------
  logic [2:0] wdt_sync_ff;
  logic       wdt_req_ff;
  wire        wdt_agree = (wdt_sync_ff[1] == wdt_sync_ff[2]);

  always_ff @(posedge CLK) begin
    if (RESET) begin
      wdt_sync_ff <= 3'h0;
      wdt_req_ff  <= 1'b0;
    end else begin
      wdt_sync_ff <= {wdt_sync_ff[1:0], WDT_REQ};
      wdt_req_ff  <= wdt_agree ? wdt_sync_ff[2] : wdt_req_ff;
    end
  end

  // ----------------------------------------------------------------
  // Source mapping onto rank order
  // ----------------------------------------------------------------
  wire [23:0] src_flat = {4'h0, PORT_C_REQ, PORT_A_REQ, PERIPH_REQ} & PIRU_VALID_FLAT;
  wire [2:0]  trap_in  = {ILLEGAL_TRAP, WDT_OSC_FAIL, PRIM_OSC_FAIL};
  wire        wdt_live = wdt_req_ff && WDT_IRQ_EN && gate_ff;

  logic [PIRU_NUM_ORD-1:0]   ord_pend;
  logic [PIRU_NUM_ORD-1:0]   ord_ack;
  logic [PIRU_NUM_ORD-1:0]   ord_src;
  logic [2*PIRU_NUM_ORD-1:0] ord_lvl;
  logic [2:0]                trap_ack;
  logic [23:0]               ack_flat;

  for (genvar k = 0; k < PIRU_NUM_ORD; k++) begin : g_ord
    assign ord_pend[k]       = pend_ff[PIRU_ORD_MAP[k]];
    assign ord_src[k]        = src_flat[PIRU_ORD_MAP[k]];
    assign ord_lvl[2*k +: 2] = {enh_ff[PIRU_ORD_MAP[k]], enl_ff[PIRU_ORD_MAP[k]]};
    assign ord_ack[k]        = INT_ACK && req_ff && (vec_ff == PIRU_VEC_W'(k + PIRU_SRC_ORD0));
  end

  for (genvar j = 0; j < PIRU_NUM_TRAP; j++) begin : g_trap
    assign trap_ack[j] = INT_ACK && req_ff && (vec_ff == PIRU_VEC_W'(j + 1));
  end

  always_comb begin
    ack_flat = '0;
    for (int k = 0; k < PIRU_NUM_ORD; k++) begin
      ack_flat[PIRU_ORD_MAP[k]] = ord_ack[k];
    end
  end

  // Set beats acknowledge and software clear; write stores 0 or 1
  assign nxt_pend = PIRU_VALID_FLAT &
                    (src_flat | (((wr_pend & wdata_flat) | (~wr_pend & pend_ff)) & ~ack_flat));
  assign nxt_trap = trap_in | (trap_ff & ~trap_ack);

  // ----------------------------------------------------------------
  // Ranking
  // ----------------------------------------------------------------
  wire [PIRU_NUM_SRC-1:0]   enc_req = {ord_pend & {PIRU_NUM_ORD{gate_ff}}, trap_ff, wdt_live};
  wire [2*PIRU_NUM_SRC-1:0] enc_lvl = {ord_lvl, {4{PIRU_LVL_3}}};
  logic                     win_valid;
  logic [PIRU_VEC_W-1:0]    win_idx;
  logic [1:0]               win_lvl;

  piru_prio_enc #(
    .NSRC  (PIRU_NUM_SRC),
    .IDX_W (PIRU_VEC_W)
  ) u_enc (
    .req     (enc_req),
    .lvl     (enc_lvl),
    .valid   (win_valid),
    .idx     (win_idx),
    .win_lvl (win_lvl)
  );

  // ----------------------------------------------------------------
  // Master gate
  // ----------------------------------------------------------------
  wire gate_set = EI_EXEC || IRET_EXEC || (wr_ctrl && HWDATA[PIRU_CTRL_GATE_BIT]);
  wire gate_clr = DI_EXEC || INT_ACK || TRAP_EXEC || (|trap_in) ||
                  (wr_ctrl && !HWDATA[PIRU_CTRL_GATE_BIT]);
  assign nxt_gate = gate_clr ? 1'b0 : (gate_set ? 1'b1 : gate_ff);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RESET) begin
      bus_ff   <= BUS_IDLE;
      addr_ff  <= '0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      bus_ff   <= nxt_bus;
      addr_ff  <= addr_take ? HADDR[31:2] : addr_ff;
      rdata_ff <= (bus_ff == BUS_RDWAIT) ? {24'h00_0000, rd_mux} : rdata_ff;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      pend_ff <= PIRU_PEND_RST;
      enh_ff  <= PIRU_EN_RST;
      enl_ff  <= PIRU_EN_RST;
      trap_ff <= 3'h0;
      gate_ff <= PIRU_GATE_RST;
    end else begin
      pend_ff <= nxt_pend;
      enh_ff  <= PIRU_VALID_FLAT & ((wr_enh & wdata_flat) | (~wr_enh & enh_ff));
      enl_ff  <= PIRU_VALID_FLAT & ((wr_enl & wdata_flat) | (~wr_enl & enl_ff));
      trap_ff <= nxt_trap;
      gate_ff <= nxt_gate;
    end
  end

  // Request drops for the cycle after an acknowledge
  always_ff @(posedge CLK) begin
    if (RESET) begin
      req_ff <= 1'b0;
      vec_ff <= '0;
    end else begin
      req_ff <= win_valid && !INT_ACK;
      vec_ff <= win_idx;
    end
  end

  assign INT_REQ    = req_ff;
  assign INT_VECTOR = vec_ff;
  assign IRQ_ENABLE = gate_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [PIRU_NUM_SRC-1:0] same_below;
  logic [PIRU_NUM_SRC-1:0] top_req;
  logic [PIRU_NUM_SRC-1:0] mid_req;
  for (genvar s = 0; s < PIRU_NUM_SRC; s++) begin : g_chk
    assign same_below[s] = enc_req[s] && (enc_lvl[2*s +: 2] == win_lvl) && (PIRU_VEC_W'(s) < win_idx);
    assign top_req[s]    = enc_req[s] && (enc_lvl[2*s +: 2] == PIRU_LVL_3);
    assign mid_req[s]    = enc_req[s] && (enc_lvl[2*s +: 2] == PIRU_LVL_2);
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  AST_SET_WINS: assert property ((|src_flat) |=> ((pend_ff & $past(src_flat)) == $past(src_flat)))
    else $error("Hardware request did not set its pending bit");
  AST_ACK_CLEAR: assert property (INT_ACK && !wr_en |=> ((ord_pend & $past(ord_ack & ~ord_src)) == 0))
    else $error("Acknowledged pending bit not cleared");
  AST_SW_WRITE: assert property (wr_p1 && (PORT_A_REQ == 8'h00) && !INT_ACK |=> pend_ff[15:8] == $past(HWDATA[7:0]))
    else $error("Software write to port A pending not stored");
  AST_RESERVED: assert property ((pend_ff & ~PIRU_VALID_FLAT) == 24'h00_0000)
    else $error("Reserved pending bit set");
  AST_GATE_OFF: assert property (!gate_ff && (trap_ff == 3'h0) |=> !INT_REQ)
    else $error("Request forwarded while gate closed");
  AST_TRAP_TOP: assert property ((trap_ff != 3'h0) && !INT_ACK |=> INT_REQ && (INT_VECTOR < 5'h04))
    else $error("Trap not ranked above ordinary sources");
  AST_WDT_BYPASS: assert property (wdt_live && !INT_ACK |=> INT_REQ && (INT_VECTOR == 5'h00))
    else $error("Watchdog request not presented first");
  AST_LEVEL3_WINS: assert property ((|top_req) |-> top_req[win_idx])
    else $error("Level 3 request did not win");
  AST_LEVEL2_WINS: assert property ((|mid_req) && !(|top_req) |-> mid_req[win_idx])
    else $error("Level 2 request lost to a lower level");
  AST_WDT_SYNC: assert property (wdt_agree |=> wdt_req_ff == $past(wdt_sync_ff[2]))
    else $error("Watchdog request did not follow its synchroniser");
  AST_FIXED_ORDER: assert property (win_valid |-> same_below == '0)
    else $error("Lower ranked source chosen within a level");
  AST_GATE_CLEAR: assert property (INT_ACK || DI_EXEC || TRAP_EXEC ##1 1'b1 |-> !IRQ_ENABLE)
    else $error("Master gate not cleared");
  AST_VEC_TRACK: assert property (!INT_ACK |=> INT_VECTOR == $past(win_idx) && INT_REQ == $past(win_valid))
    else $error("Vector output does not follow winner");

  COV_ORD_ACK: cover property (INT_REQ && INT_ACK && (INT_VECTOR >= 5'h04));
  COV_TRAP_ACK: cover property (INT_REQ && INT_ACK && (INT_VECTOR != 5'h00) && (INT_VECTOR < 5'h04));
  COV_SET_CLR: cover property (wr_p0 && (PERIPH_REQ != 8'h00) && (HWDATA[7:0] == 8'h00));
  COV_READ: cover property (bus_ff == BUS_RDDATA);

endmodule
`default_nettype wire

// ### sim/piru_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
module piru_cpu_model (
  input  wire logic       CLK,
  input  wire logic       RESET,
  input  wire logic       INT_REQ,
  input  wire logic [4:0] INT_VECTOR,
  input  wire logic [1:0] lat,
  input  wire logic [2:0] svc,
  output logic            INT_ACK,
  output logic            IRET_EXEC,
  output logic [4:0]      last_vec,
  output int              n_ack
);
  logic [2:0] cnt_ff;
  logic       busy_ff;

  // ----------------------------------------------------------------
  // Acknowledge after lat+1 request cycles, return after svc+1 busy cycles
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    INT_ACK   <= 1'b0;
    IRET_EXEC <= 1'b0;
    if (RESET) begin
      busy_ff  <= 1'b0;
      cnt_ff   <= 3'h0;
      n_ack    <= 0;
      last_vec <= 5'h00;
    end else if (busy_ff) begin
      cnt_ff <= cnt_ff + 3'h1;
      if (cnt_ff == svc) begin
        busy_ff   <= 1'b0;
        IRET_EXEC <= 1'b1;
        cnt_ff    <= 3'h0;
      end
    end else if (INT_ACK && INT_REQ) begin
      last_vec <= INT_VECTOR;
      n_ack    <= n_ack + 1;
      busy_ff  <= 1'b1;
      cnt_ff   <= 3'h0;
    end else if (INT_REQ && !INT_ACK) begin
      cnt_ff <= cnt_ff + 3'h1;
      if (cnt_ff >= {1'b0, lat}) begin
        INT_ACK <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ### sim/prioritized_interrupt_request_unit_bench.sv
`timescale 1ns/10ps
`default_nettype none
module prioritized_interrupt_request_unit_bench
  import piru_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic [7:0]  per = 8'h00;
  logic [7:0]  pa = 8'h00;
  logic [3:0]  pc = 4'h0;
  logic        wdt = 1'b0;
  logic        wdt_en = 1'b0;
  logic [5:0]  ev = 6'h00;
  logic [1:0]  lat = 2'h0;
  logic [2:0]  svc = 3'h2;
  logic        hready_out;
  logic [31:0] hrdata;
  logic        hresp;
  logic        int_ack;
  logic        iret;
  logic        int_req;
  logic [4:0]  int_vec;
  logic        irq_en;
  logic [4:0]  last_vec;
  int          n_ack;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          seed;
  int          k;
  logic [23:0] p;
  logic [23:0] h;
  logic [23:0] l;
  logic [7:0]  msk [3] = '{8'h79, 8'hff, 8'h0f};
  logic [23:0] m24;

  piru_top u_piru_top (
    .CLK(clk), .RESET(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready_out), .HREADYOUT(hready_out), .HRESP(hresp),
    .HRDATA(hrdata), .PERIPH_REQ(per), .PORT_A_REQ(pa), .PORT_C_REQ(pc), .WDT_REQ(wdt),
    .WDT_IRQ_EN(wdt_en), .PRIM_OSC_FAIL(ev[5]), .WDT_OSC_FAIL(ev[4]), .ILLEGAL_TRAP(ev[3]),
    .EI_EXEC(ev[2]), .DI_EXEC(ev[1]), .IRET_EXEC(iret), .TRAP_EXEC(ev[0]), .INT_ACK(int_ack),
    .INT_REQ(int_req), .INT_VECTOR(int_vec), .IRQ_ENABLE(irq_en)
  );

  piru_cpu_model u_piru_cpu_model (
    .CLK(clk), .RESET(rst), .INT_REQ(int_req), .INT_VECTOR(int_vec), .lat(lat), .svc(svc),
    .INT_ACK(int_ack), .IRET_EXEC(iret), .last_vec(last_vec), .n_ack(n_ack)
  );

  always #2.5 clk = ~clk;

  // ----------------------------------------------------------------
  // Checking and bus helpers
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [29:0] ix(input int i, input int j);
    return 30'(PIRU_IDX_PEND0 + 3 * i + j);
  endfunction

  function automatic int best(input logic [23:0] pp, input logic [23:0] hh, input logic [23:0] ll);
    for (int v = 3; v > 0; v--) begin
      for (int s = 0; s < PIRU_NUM_ORD; s++) begin
        if (pp[PIRU_ORD_MAP[s]] && {hh[PIRU_ORD_MAP[s]], ll[PIRU_ORD_MAP[s]]} == 2'(v)) return s;
      end
    end
    return 99;
  endfunction

  task automatic addr(input logic [29:0] idx, input logic w);
    hsel   <= 1'b1;
    haddr  <= {idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge clk);
    while (hready_out !== 1'b1) @(posedge clk);
    htrans <= 2'b00;
    hsel   <= 1'b0;
  endtask

  // Optional hardware pulse lands on the same edge as the write
  task automatic wr(input logic [29:0] idx, input logic [7:0] d, input logic [7:0] hw);
    addr(idx, 1'b1);
    hwdata <= {24'h00_0000, d};
    per    <= hw;
    @(posedge clk);
    while (hready_out !== 1'b1) @(posedge clk);
    per <= 8'h00;
  endtask

  task automatic rdchk(input logic [29:0] idx, input logic [31:0] exp);
    addr(idx, 1'b0);
    @(posedge clk);
    while (hready_out !== 1'b1) @(posedge clk);
    chk(hrdata, exp);
    chk({31'h0, hresp}, 32'h0000_0000);
  endtask

  task automatic pulse(input logic [5:0] m);
    ev <= m;
    @(posedge clk);
    ev <= 6'h00;
  endtask

  task automatic wait_ack(input logic [4:0] exp);
    int prev;
    prev = n_ack;
    while (n_ack == prev) @(posedge clk);
    chk({27'h0, last_vec}, {27'h0, exp});
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = $urandom(7);
    m24 = {msk[2], msk[1], msk[0]};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 9; i++) rdchk(ix(i / 3, i % 3), 32'h0000_0000);
    rdchk(PIRU_IDX_CTRL + 30'h1, 32'h0000_0000);
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      wr(ix(i, 0), 8'hff, 8'h00);
      rdchk(ix(i, 0), {24'h00_0000, msk[i]});
      wr(ix(i, 0), 8'h00, 8'h00);
      rdchk(ix(i, 0), 32'h0000_0000);
    end
    p = 24'($urandom);
    per <= p[7:0];
    pa  <= p[15:8];
    pc  <= p[19:16];
    @(posedge clk);
    per <= 8'h00;
    pa  <= 8'h00;
    pc  <= 4'h0;
    for (int i = 0; i < 3; i++) rdchk(ix(i, 0), {24'h00_0000, p[8*i +: 8] & msk[i]});
    for (int i = 0; i < 3; i++) wr(ix(i, 0), 8'h00, 8'h00);
    wr(ix(0, 0), 8'h00, 8'h20);
    rdchk(ix(0, 0), 32'h0000_0020);
    wr(ix(0, 0), 8'h00, 8'h00);
    $display("test pending bits done");
    for (int r = 0; r < 8; r++) begin
      p = 24'($urandom);
      h = (r == 0) ? 24'hff_ffff : 24'($urandom);
      l = (r == 0) ? 24'h00_0000 : 24'($urandom);
      lat <= 2'($urandom);
      svc <= 3'(1 + $urandom % 7);
      for (int i = 0; i < 3; i++) begin
        wr(ix(i, 1), h[8*i +: 8], 8'h00);
        wr(ix(i, 2), l[8*i +: 8], 8'h00);
        wr(ix(i, 0), p[8*i +: 8], 8'h00);
        rdchk(ix(i, 1), {24'h00_0000, h[8*i +: 8] & msk[i]});
        rdchk(ix(i, 2), {24'h00_0000, l[8*i +: 8] & msk[i]});
      end
      p = p & m24;
      h = h & m24;
      l = l & m24;
      chk({31'h0, int_req}, 32'h0000_0000);
      wr(PIRU_IDX_CTRL, 8'h80, 8'h00);
      for (k = best(p, h, l); k < 99; k = best(p, h, l)) begin
        wait_ack(5'(k + PIRU_SRC_ORD0));
        p[PIRU_ORD_MAP[k]] = 1'b0;
      end
      repeat (12) @(posedge clk);
      for (int i = 0; i < 3; i++) rdchk(ix(i, 0), {24'h00_0000, p[8*i +: 8]});
      wr(PIRU_IDX_CTRL, 8'h00, 8'h00);
    end
    $display("test priority done");
    svc <= 3'h2;
    for (int t = 0; t < 3; t++) begin
      pulse(6'h20 >> t);
      wait_ack(5'(t + 1));
    end
    repeat (8) @(posedge clk);
    pulse(6'h02);
    @(posedge clk);
    chk({31'h0, irq_en}, 32'h0000_0000);
    wdt_en <= 1'b1;
    wdt    <= 1'b1;
    svc    <= 3'h7;
    wr(ix(0, 1), 8'h40, 8'h00);
    wr(ix(0, 2), 8'h40, 8'h00);
    wr(ix(0, 0), 8'h40, 8'h00);
    pulse(6'h04);
    wait_ack(5'h00);
    wdt <= 1'b0;
    wait_ack(5'h04);
    repeat (8) @(posedge clk);
    wr(PIRU_IDX_CTRL, 8'h00, 8'h00);
    pulse(6'h04);
    @(posedge clk);
    chk({31'h0, irq_en}, 32'h0000_0001);
    pulse(6'h01);
    @(posedge clk);
    chk({31'h0, irq_en}, 32'h0000_0000);
    $display("test traps and gate done");
    wr(ix(2, 0), 8'h0f, 8'h00);
    wr(PIRU_IDX_CTRL, 8'h80, 8'h00);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({31'h0, irq_en}, 32'h0000_0000);
    rdchk(ix(2, 0), 32'h0000_0000);
    $display("test mid-run reset done");
    conclude();
  end
endmodule
`default_nettype wire
